// [rtl/tsr_map.vh]
// Constants for the temperature sensor serial read and alarm block
// Function
// - Master gives 8 or 16 clocks by register width; device shifts data out.
// - First data bit appears on first falling clock after the command byte.
// - One register per transaction; each further read needs a new command.
// - Continuous read bit set: temperature repeats every 16 clocks, no command.
// - In frame sync use, MSB is driven as soon as chip select falls.
// - Free-running clock tolerated; no shifting while chip select is high.
// - Three-wire use with chip select tied low must work.
// - Data in high for 32 clocks resets the serial state machine.
// - After interface reset the device expects a command byte.
// - Interface reset restores every register to its power-on value.
// - Alarm has comparator and interrupt behaviour; interrupt after power-up.
// - Alarm asserts when temperature above high limit or below low limit.
// - Comparator: alarm clears below high minus hysteresis or above low plus.
// - Comparator: entering shutdown leaves the alarm unchanged.
// - Interrupt: any register read clears the alarm.
// - Interrupt: after clearing, alarm reasserts only on a new limit crossing.
// - Interrupt: entering shutdown clears the alarm.
// - Command: bit 7 zero, bit 6 read, bits 5..3 address, bit 2 continuous.
// - Data in sampled on rising clock; data out changes on falling clock.
// - Hysteresis is an unsigned four-bit count in the low bits of its register.
`ifndef TSR_MAP_VH
`define TSR_MAP_VH
`define TSR_CMD_BIT_ZERO  7
`define TSR_CMD_BIT_RW    6
`define TSR_CMD_ADDR_HI   5
`define TSR_CMD_ADDR_LO   3
`define TSR_CMD_BIT_CONT  2
`define TSR_ADDR_STATUS   3'h0
`define TSR_ADDR_CONFIG   3'h1
`define TSR_ADDR_TEMP     3'h2
`define TSR_ADDR_ID       3'h3
`define TSR_ADDR_CRIT     3'h4
`define TSR_ADDR_HYST     3'h5
`define TSR_ADDR_HIGH     3'h6
`define TSR_ADDR_LOW      3'h7
`define TSR_RST_ONES      6'h20
`define TSR_CMD_BITS      4'h8
`define TSR_HYST_W        4
`define TSR_RST_HYST      8'h05
`define TSR_RST_HIGH      16'h2000
`define TSR_RST_LOW       16'h0500
`define TSR_RST_CRIT      16'h4980
`define TSR_RST_CONFIG    8'h00
`define TSR_CFG_BIT_CMP   4
`define TSR_HYST_SHIFT    7
`endif

// [rtl/tsr_sync.v]
// Two-flop synchroniser with rising and falling edge detection
`timescale 1ns/100ps
module tsr_sync #(
   parameter INIT = 1'b0
) (
   input  wire mclk,      // System clock
   input  wire rst,       // Synchronous reset, active high
   input  wire pin,       // Asynchronous input
   output wire level,     // Synchronised level
   output wire rise,      // One-cycle pulse on rising edge
   output wire fall       // One-cycle pulse on falling edge
);
   reg stage1;
   reg stage2;
   reg stage3;

   // First flop feeds only the second; edges are taken from later stages
   always @(posedge mclk) begin
      if (rst) begin
         stage1 <= INIT;
         stage2 <= INIT;
         stage3 <= INIT;
      end else begin
         stage1 <= pin;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   assign level = stage2;
   assign rise  = stage2 & ~stage3;
   assign fall  = ~stage2 & stage3;
endmodule

// [rtl/tsr_alarm.v]
// Temperature limit alarm with comparator and interrupt behaviour
`timescale 1ns/100ps
`include "tsr_map.vh"
module tsr_alarm #(
   parameter TW = 16
) (
   input  wire          mclk,        // System clock
   input  wire          rst,         // Synchronous reset, active high
   input  wire          cmp_mode,    // 1 comparator, 0 interrupt
   input  wire [TW-1:0] temp,        // Measured temperature, twos complement
   input  wire [TW-1:0] high_limit,  // Over-temperature limit
   input  wire [TW-1:0] low_limit,   // Under-temperature limit
   input  wire [7:0]    hysteresis,  // Hysteresis register
   input  wire          shutdown,    // Shutdown level
   input  wire          reg_read,    // Pulse: some register was read
   output reg           alarm        // Alarm state, active high
);
   wire signed [TW+1:0] t_s;
   wire signed [TW+1:0] hi_s;
   wire signed [TW+1:0] lo_s;
   wire signed [TW+1:0] hy_s;
   wire                 over;
   wire                 under;
   wire                 cleared_cmp;
   reg                  prev_out;
   reg                  shut_d;

   assign t_s  = {{2{temp[TW-1]}}, temp};
   assign hi_s = {{2{high_limit[TW-1]}}, high_limit};
   assign lo_s = {{2{low_limit[TW-1]}}, low_limit};
   // Whole degrees scaled to temperature LSBs (1/128 deg in 16-bit format)
   assign hy_s = $signed({{(TW+2-`TSR_HYST_W-`TSR_HYST_SHIFT){1'b0}},
                          hysteresis[`TSR_HYST_W-1:0],
                          {`TSR_HYST_SHIFT{1'b0}}});
   assign over  = t_s > hi_s;
   assign under = t_s < lo_s;
   assign cleared_cmp = (t_s < hi_s - hy_s) && (t_s > lo_s + hy_s);

   // In interrupt mode event detection is edge based so a held condition cannot re-fire; comparator mode follows the level
   always @(posedge mclk) begin
      if (rst) begin
         alarm    <= 1'b0;
         prev_out <= 1'b0;
         shut_d   <= 1'b0;
      end else begin
         prev_out <= over | under;
         shut_d   <= shutdown;
         if (cmp_mode) begin
            // Shutdown is ignored here, alarm holds its state
            if (over | under)
               alarm <= 1'b1;
            else if (cleared_cmp)
               alarm <= 1'b0;
         end else begin
            if ((over | under) & ~prev_out & ~shutdown)
               alarm <= 1'b1;
            else if (reg_read | (shutdown & ~shut_d))
               alarm <= 1'b0;
         end
      end
   end
endmodule

// [rtl/tsr_spi_read.v]
// Serial read interface and alarm outputs of the temperature sensor
`timescale 1ns/100ps
`include "tsr_map.vh"
module tsr_spi_read #(
   parameter TW     = 16,
   parameter ID_VAL = 8'hA5   // Arbitrary identity value
) (
   input  wire          mclk,          // System clock, 100 MHz
   input  wire          rst,           // Synchronous reset, active high
   input  wire          cs_n,          // Chip select pin, active low
   input  wire          sclk,          // Serial clock pin
   input  wire          sdi,           // Serial data in pin
   output reg           sdo,           // Serial data out, registered
   output wire          sdo_oe_n,      // Data out enable, low drives
   input  wire [TW-1:0] temp_value,    // Temperature from converter
   input  wire [7:0]    status_value,  // Status register contents
   input  wire          shutdown,      // Shutdown level
   output wire          alarm_out,     // Alarm level, active high
   output wire          alarm_oe_n,    // Open-drain enable, low pulls
   output wire          critical_out,  // Critical level, active high
   output wire [7:0]    config_reg,    // Configuration register
   output wire [TW-1:0] high_limit,    // Over-temperature limit
   output wire [TW-1:0] low_limit,     // Under-temperature limit
   output wire [TW-1:0] crit_limit,    // Critical limit
   output wire [7:0]    hysteresis,    // Hysteresis register
   output wire          if_reset       // Pulse: interface reset taken
);
   localparam ST_CMD  = 3'b001;
   localparam ST_DATA = 3'b010;
   localparam ST_IDLE = 3'b100;

   wire       cs_lvl;
   wire       cs_fall;
   wire       sck_rise;
   wire       sck_fall;
   wire       di_lvl;
   wire       active;
   reg  [2:0] state;
   reg  [2:0] next_state;
   reg  [7:0] cmd_sh;
   reg  [3:0] bit_cnt;
   reg  [4:0] out_cnt;
   reg  [15:0] out_sh;
   reg        cont;
   reg  [5:0] ones_cnt;
   reg        ones_rst;
   reg        reg_read;
   reg  [7:0]    cfg_q;
   reg  [TW-1:0] high_q;
   reg  [TW-1:0] low_q;
   reg  [TW-1:0] crit_q;
   reg  [7:0]    hyst_q;
   reg  [15:0] rd_word;
   reg        rd_wide;
   wire [7:0] cmd_next;
   wire       alarm;

   // Select idles high so no false fall follows reset
   tsr_sync #(.INIT(1'b1)) u_cs (
      .mclk  (mclk),
      .rst   (rst),
      .pin   (cs_n),
      .level (cs_lvl),
      .rise  (),
      .fall  (cs_fall)
   );
   // Clock parks high between frames, matching the reset value
   tsr_sync #(.INIT(1'b1)) u_sck (
      .mclk  (mclk),
      .rst   (rst),
      .pin   (sclk),
      .level (),
      .rise  (sck_rise),
      .fall  (sck_fall)
   );
   // Data in is only read at a detected clock rise
   tsr_sync #(.INIT(1'b0)) u_di (
      .mclk  (mclk),
      .rst   (rst),
      .pin   (sdi),
      .level (di_lvl),
      .rise  (),
      .fall  ()
   );

   // Chip select may be tied low for three-wire use
   assign active   = ~cs_lvl;
   assign cmd_next = {cmd_sh[6:0], di_lvl};
   assign sdo_oe_n = ~active;

   // Register selected by the command address
   always @* begin
      rd_word = 16'h0000;
      rd_wide = 1'b1;
      case (cmd_next[`TSR_CMD_ADDR_HI:`TSR_CMD_ADDR_LO])
         `TSR_ADDR_STATUS: begin
            rd_word = {status_value, 8'h00};
            rd_wide = 1'b0;
         end
         `TSR_ADDR_CONFIG: begin
            rd_word = {cfg_q, 8'h00};
            rd_wide = 1'b0;
         end
         `TSR_ADDR_TEMP:   rd_word = temp_value;
         `TSR_ADDR_ID: begin
            rd_word = {ID_VAL, 8'h00};
            rd_wide = 1'b0;
         end
         `TSR_ADDR_CRIT:   rd_word = crit_q;
         `TSR_ADDR_HYST: begin
            rd_word = {hyst_q, 8'h00};
            rd_wide = 1'b0;
         end
         `TSR_ADDR_HIGH:   rd_word = high_q;
         `TSR_ADDR_LOW:    rd_word = low_q;
         default:          rd_word = 16'h0000;
      endcase
   end

   // Next state of the command and data sequencer
   always @* begin
      next_state = state;
      case (state)
         ST_CMD: begin
            if (sck_rise && bit_cnt == `TSR_CMD_BITS - 4'h1) begin
               if (cmd_next[`TSR_CMD_BIT_RW] && !cmd_next[`TSR_CMD_BIT_ZERO])
                  next_state = ST_DATA;
               else
                  next_state = ST_IDLE;           // Writes not handled here
            end
         end
         ST_DATA: begin
            // Back to command so three-wire use needs no select edge
            if (sck_fall && out_cnt == 5'h00 && !cont)
               next_state = ST_CMD;
         end
         ST_IDLE:  next_state = ST_IDLE;
         default:  next_state = ST_CMD;
      endcase
   end

   // Sequencer, shifter and long-ones interface reset
   always @(posedge mclk) begin
      reg_read <= 1'b0;
      ones_rst <= 1'b0;
      if (rst || ones_rst || !active) begin
         state   <= ST_CMD;
         cmd_sh  <= 8'h00;
         bit_cnt <= 4'h0;
         out_cnt <= 5'h00;
         out_sh  <= 16'h0000;
         cont    <= 1'b0;
         // A deselect breaks the run of ones, so a new frame counts afresh
         ones_cnt <= 6'h00;
      end else begin
         state <= next_state;
         if (sck_rise) begin
            // Count consecutive ones on rising edges
            if (di_lvl && ones_cnt == `TSR_RST_ONES - 6'h01)
               ones_rst <= 1'b1;
            ones_cnt <= di_lvl ? ones_cnt + 6'h01 : 6'h00;
         end
         if (state == ST_CMD && sck_rise) begin
            cmd_sh  <= cmd_next;
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == `TSR_CMD_BITS - 4'h1 && next_state == ST_DATA) begin
               out_sh   <= rd_word;
               out_cnt  <= rd_wide ? 5'h10 : 5'h08;
               cont     <= cmd_next[`TSR_CMD_BIT_CONT] &&
                  cmd_next[`TSR_CMD_ADDR_HI:`TSR_CMD_ADDR_LO] == `TSR_ADDR_TEMP;
               reg_read <= 1'b1;
            end
         end else if (state == ST_DATA && sck_fall) begin
            if (out_cnt == 5'h00) begin
               // Continuous mode reloads temperature every 16 clocks
               out_sh  <= {temp_value[14:0], 1'b0};
               out_cnt <= 5'h0F;
               bit_cnt <= 4'h0;                   // Rearm command shifter
            end else begin
               out_sh  <= {out_sh[14:0], 1'b0};
               out_cnt <= out_cnt - 5'h01;
            end
         end
      end
   end

   // Data out: first bit on the first falling edge after the command
   always @(posedge mclk) begin
      if (rst || !active)
         sdo <= 1'b1;
      else if (cs_fall)
         sdo <= temp_value[TW-1];
      else if (state == ST_DATA && sck_fall)
         sdo <= (out_cnt == 5'h00) ? temp_value[TW-1] : out_sh[15];
   end

   // Registers hold power-on values; long-ones reset restores them
   always @(posedge mclk) begin
      if (rst || ones_rst) begin
         cfg_q  <= `TSR_RST_CONFIG;
         high_q <= `TSR_RST_HIGH;
         low_q  <= `TSR_RST_LOW;
         crit_q <= `TSR_RST_CRIT;
         hyst_q <= `TSR_RST_HYST;
      end
   end

   tsr_alarm #(.TW(TW)) u_alarm (
      .mclk       (mclk),
      .rst        (rst),
      .cmp_mode   (cfg_q[`TSR_CFG_BIT_CMP]),
      .temp       (temp_value),
      .high_limit (high_q),
      .low_limit  (low_q),
      .hysteresis (hyst_q),
      .shutdown   (shutdown),
      .reg_read   (reg_read),
      .alarm      (alarm)
   );

   // Critical limit logic lives elsewhere; output held inactive
   assign critical_out = 1'b0;
   assign alarm_out    = alarm;
   assign alarm_oe_n   = ~alarm;
   assign config_reg   = cfg_q;
   assign high_limit   = high_q;
   assign low_limit    = low_q;
   assign crit_limit   = crit_q;
   assign hysteresis   = hyst_q;
   assign if_reset     = ones_rst;
endmodule

// [sim/tsr_master.sv]
// Serial bus master model that drives chip select, clock and data in
`timescale 1ns/100ps
module tsr_master (
   input  wire mclk,   // Bench clock, paces the serial clock
   output reg  cs_n,   // Chip select, active low
   output reg  sclk,   // Serial clock, 80 ns period
   output reg  sdi,    // Serial data to the device
   input  wire sdo     // Serial data from the device
);
   // Idle deselected with the clock parked high
   initial begin
      cs_n = 1'b1;
      sclk = 1'b1;
      sdi  = 1'b0;
   end
   // One clock: data set on the fall, data out taken just before the rise
   task automatic pulse(input logic din, output logic dout);
      begin
         sclk = 1'b0;
         sdi  = din;
         repeat (4) @(negedge mclk);
         dout = sdo;
         sclk = 1'b1;
         repeat (4) @(negedge mclk);
      end
   endtask
   // Command byte, then nbits of data; keep_low leaves chip select down
   task automatic xfer(input logic [7:0] cmd, input integer nbits, input logic keep_low,
                       output logic [47:0] data, output logic fs);
      integer i;
      logic   b;
      begin
         data = 48'h0;
         cs_n = 1'b0;
         repeat (8) @(negedge mclk);
         fs = sdo;
         for (i = 0; i < 8; i = i + 1)
            pulse(cmd[7-i], b);
         for (i = 0; i < nbits; i = i + 1) begin
            pulse(1'b0, b);
            data = {data[46:0], b};
         end
         if (!keep_low)
            cs_n = 1'b1;
         repeat (8) @(negedge mclk);
      end
   endtask
   // Run of ones on data in; a full reset is followed by the settling wait
   task automatic ones(input integer n, input logic keep_low);
      integer i;
      logic   b;
      begin
         cs_n = 1'b0;
         repeat (8) @(negedge mclk);
         for (i = 0; i < n; i = i + 1)
            pulse(1'b1, b);
         sdi = 1'b0;
         if (!keep_low)
            cs_n = 1'b1;
         repeat (8) @(negedge mclk);
         if (n >= 32)
            repeat (50000) @(negedge mclk);
      end
   endtask
   // Free-running clock with data high while deselected
   task automatic idle(input integer n);
      integer i;
      logic   b;
      begin
         cs_n = 1'b1;
         for (i = 0; i < n; i = i + 1)
            pulse(1'b1, b);
         sdi = 1'b0;
      end
   endtask
endmodule

// [sim/tsr_spi_read_checker.sv]
// Port assertions for the serial read and alarm block
`timescale 1ns/100ps
module tsr_spi_read_checker #(
   parameter TW = 16
) (
   input wire          mclk,          // System clock
   input wire          rst,           // Synchronous reset
   input wire          cs_n,          // Chip select
   input wire          sclk,          // Serial clock
   input wire          sdi,           // Data in
   input wire          sdo,           // Data out
   input wire          sdo_oe_n,      // Data out enable
   input wire [TW-1:0] temp_value,    // Temperature
   input wire [7:0]    status_value,  // Status contents
   input wire          shutdown,      // Shutdown level
   input wire          alarm_out,     // Alarm level
   input wire          alarm_oe_n,    // Alarm pull enable
   input wire          critical_out,  // Critical level
   input wire [7:0]    config_reg,    // Configuration
   input wire [TW-1:0] high_limit,    // High limit
   input wire [TW-1:0] low_limit,     // Low limit
   input wire [TW-1:0] crit_limit,    // Critical limit
   input wire [7:0]    hysteresis,    // Hysteresis
   input wire          if_reset       // Interface reset pulse
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   wire      over  = $signed(temp_value) > $signed(high_limit);
   wire      under = $signed(temp_value) < $signed(low_limit);
   reg       over_d;
   reg       under_d;
   reg       sclk_d;
   reg       cs_d;
   reg [3:0] quiet;
   reg [3:0] since_x;
   // Ages since the last clock fall or select change, and since a fresh crossing
   always @(posedge mclk) begin
      over_d  <= over;
      under_d <= under;
      sclk_d  <= sclk;
      cs_d    <= cs_n;
      if (rst || (sclk_d && !sclk) || (cs_d != cs_n))
         quiet <= 4'h0;
      else if (quiet != 4'hF)
         quiet <= quiet + 4'h1;
      if (rst || (over && !over_d) || (under && !under_d))
         since_x <= 4'h0;
      else if (since_x != 4'hF)
         since_x <= since_x + 4'h1;
   end
   sequence cs_open;
      $fell(cs_n) ##1 (!cs_n && sclk)[*6];
   endsequence
   sequence fresh_cross;
      !shutdown && ($rose(over) || $rose(under));
   endsequence
   idle_sdo_a: assert property (cs_n[*4] |-> sdo && sdo_oe_n)
      else $error("data out active while deselected");
   drive_oe_a: assert property ((!cs_n)[*4] |-> !sdo_oe_n)
      else $error("data out not driven while selected");
   frame_msb_a: assert property (cs_open |-> sdo == temp_value[TW-1])
      else $error("select fall did not present the sign bit");
   sdo_edge_a: assert property ($changed(sdo) |-> quiet < 4'h7)
      else $error("data out moved away from a clock fall");
   alarm_pin_a: assert property (alarm_oe_n == !alarm_out)
      else $error("alarm pull enable disagrees with alarm");
   alarm_set_a: assert property (fresh_cross |-> ##[1:4] alarm_out)
      else $error("limit crossing did not raise alarm");
   alarm_new_a: assert property ($rose(alarm_out) |-> since_x < 4'h5)
      else $error("alarm rose without a new crossing");
   shut_clear_a: assert property (!config_reg[4] && $rose(shutdown) |-> ##[1:3] !alarm_out)
      else $error("shutdown did not clear alarm");
   pulse_once_a: assert property (if_reset |=> !if_reset)
      else $error("interface reset pulse too long");
   reg_default_a: assert property (high_limit == 16'h2000 && low_limit == 16'h0500 &&
      crit_limit == 16'h4980 && hysteresis == 8'h05 && config_reg == 8'h00 && !critical_out)
      else $error("register left its power-on value");
endmodule
bind tsr_spi_read tsr_spi_read_checker #(.TW(TW)) chk (.mclk(mclk), .rst(rst), .cs_n(cs_n),
   .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .temp_value(temp_value),
   .status_value(status_value), .shutdown(shutdown), .alarm_out(alarm_out),
   .alarm_oe_n(alarm_oe_n), .critical_out(critical_out), .config_reg(config_reg),
   .high_limit(high_limit), .low_limit(low_limit), .crit_limit(crit_limit),
   .hysteresis(hysteresis), .if_reset(if_reset));

// [sim/testbench.sv]
// Self-checking bench for the serial read and alarm block
`timescale 1ns/100ps
module testbench;
   reg          mclk;
   reg          rst;
   reg  [15:0]  temp_value;
   reg  [7:0]   status_value;
   reg          shutdown;
   wire         cs_n, sclk, sdi, sdo, sdo_oe_n, alarm_out, alarm_oe_n, critical_out, if_reset;
   wire [7:0]   config_reg, hysteresis;
   wire [15:0]  high_limit, low_limit, crit_limit;
   integer      mismatches, comparisons, resets, i;
   reg  [47:0]  data;
   reg          fs;
   // Expected contents per address, low address in the low slice
   localparam [127:0] VALS = {16'h0500, 16'h2000, 16'h0005, 16'h4980,
                              16'h00A5, 16'h1234, 16'h0000, 16'h005A};
   localparam [7:0]   WIDE = 8'hD4;
   tsr_spi_read dut (.mclk(mclk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo),
      .sdo_oe_n(sdo_oe_n), .temp_value(temp_value), .status_value(status_value),
      .shutdown(shutdown), .alarm_out(alarm_out), .alarm_oe_n(alarm_oe_n),
      .critical_out(critical_out), .config_reg(config_reg), .high_limit(high_limit),
      .low_limit(low_limit), .crit_limit(crit_limit), .hysteresis(hysteresis),
      .if_reset(if_reset));
   tsr_master m (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo));
   // 100 MHz clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // Count interface reset pulses
   always @(posedge mclk) begin
      if (if_reset === 1'b1)
         resets = resets + 1;
   end
   task check(input logic [47:0] seen, input logic [47:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
         end
      end
   endtask
   task print_verdict;
      begin
         $display("comparisons %0d mismatches %0d", comparisons, mismatches);
         if (mismatches == 0 && comparisons > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   // Watchdog sized well past the longest sequence, settling wait included
   initial begin
      repeat (70000) @(posedge mclk);
      mismatches = mismatches + 1;
      $display("watchdog expired");
      print_verdict;
   end
   // Main sequence
   initial begin
      mismatches = 0;
      comparisons = 0;
      resets = 0;
      rst = 1'b1;
      temp_value = 16'h1234;
      status_value = 8'h5A;
      shutdown = 1'b0;
      repeat (5) @(posedge mclk);
      @(negedge mclk) rst = 1'b0;
      repeat (4) @(negedge mclk);
      check({high_limit, low_limit, crit_limit}, 48'h2000_0500_4980);
      check({hysteresis, config_reg, sdo, alarm_out}, 18'h01402);
      $display("test defaults done");
      for (i = 0; i < 8; i = i + 1) begin
         m.xfer({2'b01, i[2:0], 3'b000}, WIDE[i] ? 16 : 8, 1'b0, data, fs);
         check(data, VALS[i*16 +: 16]);
         check(fs, 1'b0);
      end
      $display("test register reads done");
      m.xfer(8'h54, 48, 1'b0, data, fs);
      check(data, {3{16'h1234}});
      $display("test continuous read done");
      m.idle(40);
      m.ones(31, 1'b0);
      check(resets, 0);
      m.ones(32, 1'b1);
      check(resets, 1);
      m.xfer(8'h50, 16, 1'b1, data, fs);
      check(data, 16'h1234);
      m.xfer(8'h58, 8, 1'b0, data, fs);
      check(data, 8'hA5);
      $display("test interface reset done");
      temp_value = 16'h2100;
      repeat (6) @(negedge mclk);
      check(alarm_out, 1'b1);
      m.xfer(8'h40, 8, 1'b0, data, fs);
      check(alarm_out, 1'b0);
      repeat (20) @(negedge mclk);
      check(alarm_out, 1'b0);
      temp_value = 16'h1000;
      repeat (6) @(negedge mclk);
      temp_value = 16'h0400;
      repeat (6) @(negedge mclk);
      check(alarm_out, 1'b1);
      shutdown = 1'b1;
      repeat (6) @(negedge mclk);
      check(alarm_out, 1'b0);
      $display("test alarm done");
      print_verdict;
   end
endmodule
